//--- core/nbt_target.sv
// Target end of the nibble bus: decodes single-byte read and write cycles.
// Assumes bus pins arrive from outside; they pass two flops before use.
`timescale 1ns/10ps
`default_nettype none
module nbt_target (
  input wire logic clk,
  input wire logic rstn,
  nbt_if.target bus,
  input wire logic [3:0] strapped_identity,
  input wire logic [7:0] rd_byte,
  output logic [27:0] addr_q,
  output logic [7:0] wr_byte_q,
  output logic wr_stb_q,
  output logic rd_stb_q,
  output logic standby_q
);
  import nbt_pkg::*;
  // ==========================================================
  // Input synchronisers
  // R01 R15 one nibble per rising edge
  logic frame_m_q, frame_n_q;
  logic [3:0] nib_m_q, nib_q;
  logic [3:0] ident_m_q, ident_q;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      frame_m_q <= 1'b1;
      frame_n_q <= 1'b1;
      nib_m_q <= NIB_ONES;
      nib_q <= NIB_ONES;
      ident_m_q <= 4'h0;
      ident_q <= 4'h0;
    end
    else
    begin
      frame_m_q <= bus.frame_line_n;
      frame_n_q <= frame_m_q;
      nib_m_q <= bus.nibble_bus;
      nib_q <= nib_m_q;
      ident_m_q <= strapped_identity;
      ident_q <= ident_m_q;
    end

  // ==========================================================
  // Cycle sequencer
  nbt_state_t st_q;
  logic is_write_q;
  logic [2:0] acnt_q;
  logic [7:0] rbyte_q;
  logic [3:0] do_q;
  logic oe_q;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      st_q <= ST_IDLE;
      is_write_q <= 1'b0;
      acnt_q <= 3'h0;
      addr_q <= 28'h000_0000;
      wr_byte_q <= 8'h00;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      rbyte_q <= 8'h00;
    end
    else
    begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      // R16 frame mid-cycle aborts
      if (!frame_n_q && st_q != ST_IDLE && st_q != ST_ID && st_q != ST_ABORT)
        st_q <= ST_ABORT;
      else
        case (st_q)
          // R02 R03 last start before frame rises
          ST_IDLE:
            if (!frame_n_q)
            begin
              is_write_q <= (nib_q == START_WRITE);
              st_q <= (nib_q == START_READ || nib_q == START_WRITE) ? ST_ID : ST_IDLE;
            end
          ST_ID:
            // R03 frame still low: restart on newer start nibble
            if (!frame_n_q)
            begin
              is_write_q <= (nib_q == START_WRITE);
              st_q <= (nib_q == START_READ || nib_q == START_WRITE) ? ST_ID : ST_IDLE;
            end
            // R04 R19 identity compare
            else
            begin
              acnt_q <= 3'h0;
              st_q <= (nib_q == ident_q) ? ST_ADDR : ST_IDLE;
            end
          // R05 shift address, msn first
          ST_ADDR:
          begin
            addr_q <= {addr_q[23:0], nib_q};
            acnt_q <= acnt_q + 3'h1;
            if (acnt_q == ADDR_LAST_IDX)
              st_q <= ST_SIZE;
          end
          // R06 R20 size check, silent reset
          ST_SIZE:
            if (nib_q != SIZE_ONE_BYTE)
              st_q <= ST_IDLE;
            else if (is_write_q)
              st_q <= ST_WDAT_LO;
            else
            begin
              rd_stb_q <= 1'b1;
              st_q <= ST_TURNAROUND_FIRST_IN;
            end
          // R11 write data low then high
          ST_WDAT_LO:
          begin
            wr_byte_q[3:0] <= nib_q;
            st_q <= ST_WDAT_HI;
          end
          ST_WDAT_HI:
          begin
            wr_byte_q[7:4] <= nib_q;
            st_q <= ST_TURNAROUND_FIRST_IN;
          end
          // R07 R12 host turnaround
          ST_TURNAROUND_FIRST_IN:
          begin
            rbyte_q <= rd_byte;
            st_q <= ST_TURNAROUND_SECOND_IN;
          end
          ST_TURNAROUND_SECOND_IN:
            st_q <= ST_SYNC;
          ST_SYNC:
          begin
            wr_stb_q <= is_write_q;
            st_q <= is_write_q ? ST_TURNAROUND_FIRST_OUT : ST_RDAT_LO;
          end
          ST_RDAT_LO:
            st_q <= ST_RDAT_HI;
          ST_RDAT_HI:
            st_q <= ST_TURNAROUND_FIRST_OUT;
          ST_TURNAROUND_FIRST_OUT:
            st_q <= ST_TURNAROUND_SECOND_OUT;
          ST_TURNAROUND_SECOND_OUT:
            st_q <= ST_IDLE;
          // R17 abort nibble returns to ready
          ST_ABORT:
            if (frame_n_q && nib_q == ABORT_CODE)
              st_q <= ST_IDLE;
          default:
            st_q <= ST_IDLE;
        endcase
    end

  // ==========================================================
  // Bus drive, registered one clock ahead of the slot it serves
  // R22 drivers only in own slots
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      do_q <= NIB_ONES;
      oe_q <= 1'b0;
    end
    else
    begin
      do_q <= NIB_ONES;
      oe_q <= 1'b0;
      if (frame_n_q)
        case (st_q)
          // R08 R13 ready sync next slot
          ST_TURNAROUND_SECOND_IN:
          begin
            do_q <= SYNC_READY;
            oe_q <= 1'b1;
          end
          // R09 low nibble then high
          ST_SYNC:
            if (!is_write_q)
            begin
              do_q <= rbyte_q[3:0];
              oe_q <= 1'b1;
            end
            // R14 ones then release
            else
              oe_q <= 1'b1;
          ST_RDAT_LO:
          begin
            do_q <= rbyte_q[7:4];
            oe_q <= 1'b1;
          end
          // R10 ones then release
          ST_RDAT_HI:
            oe_q <= 1'b1;
          default:
            oe_q <= 1'b0;
        endcase
    end
  assign bus.tgt_do = do_q;
  assign bus.tgt_oe = oe_q;

  // R21 standby when frame high and idle
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      standby_q <= 1'b1;
    else
      standby_q <= frame_n_q && (st_q == ST_IDLE);
endmodule
`default_nettype wire

//--- pkg/nbt_pkg.sv
// Constants, types and field codes shared by both ends of the nibble bus.
// Assumes one clock feeding host and target; the interface resolves the bus wire.
// Functional notes
// R01 - One nibble per clock; single-byte transfers only
// R02 - Frame low with start 1101 read, 1110 write
// R03 - Last start nibble before frame rises counts
// R04 - Clock two select nibble must match straps
// R05 - Seven address nibbles, most significant first
// R06 - Size nibble 0000 in clock ten
// R07 - Read: host turnaround ones, target takes bus
// R08 - Read: target drives ready sync 0000, clock 13; code drives it in clock 15
// R09 - Read: low nibble clock 14, high 15; code drives them in clocks 16 and 17
// R10 - Read: target drives ones, releases; host resumes
// R11 - Write: host sends low then high nibble
// R12 - Write: host turnaround ones, target takes bus
// R13 - Write: target acknowledges with 0000, clock 15; code drives it in clock 17
// R14 - Write: target drives ones, releases; host resumes
// R15 - Fields valid and sampled on rising edge
// R16 - Frame low mid-cycle terminates, await abort
// R17 - Abort nibble 1111 returns target to ready
// R18 - Host avoids aborting during writes
// R19 - Select mismatch: ignore cycle, go standby
// R20 - Bad size: reset, no operation, no response
// R21 - Standby frame high; ready frame low idle
// R22 - Target drivers off outside its own slots
package nbt_pkg;
  localparam int NIB_W = 4;
  localparam int ADDR_W = 28;
  localparam int ADDR_NIBS = 7;
  localparam int BYTE_W = 8;
  localparam logic [3:0] START_READ = 4'hD;
  localparam logic [3:0] START_WRITE = 4'hE;
  localparam logic [3:0] SIZE_ONE_BYTE = 4'h0;
  localparam logic [3:0] NIB_ONES = 4'hF;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] ABORT_CODE = 4'hF;
  localparam logic [2:0] ADDR_LAST_IDX = 3'h6;

  // Target sequencing; Gray steps along the write path up to ST_TURNAROUND_SECOND_OUT
  typedef enum logic [4:0] {
    ST_IDLE = 5'h00,
    ST_ID = 5'h01,
    ST_ADDR = 5'h03,
    ST_SIZE = 5'h02,
    ST_WDAT_LO = 5'h06,
    ST_WDAT_HI = 5'h07,
    ST_TURNAROUND_FIRST_IN = 5'h05,
    ST_TURNAROUND_SECOND_IN = 5'h04,
    ST_SYNC = 5'h0C,
    ST_RDAT_LO = 5'h0D,
    ST_RDAT_HI = 5'h0F,
    ST_TURNAROUND_FIRST_OUT = 5'h0E,
    ST_TURNAROUND_SECOND_OUT = 5'h0A,
    ST_ABORT = 5'h0B
  } nbt_state_t;
endpackage

//--- pkg/nbt_if.sv
// Nibble bus interface joining the host end and the target end.
// Assumes both ends run on the same clk; wire level resolved from enables.
`timescale 1ns/10ps
`default_nettype none
interface nbt_if;
  logic frame_line_n;
  logic [3:0] host_do;
  logic host_oe;
  logic [3:0] tgt_do;
  logic tgt_oe;
  logic [3:0] nibble_bus;
  // Bus floats high when nobody drives, as with pull-ups
  assign nibble_bus = host_oe ? host_do : (tgt_oe ? tgt_do : 4'hF);
  modport host (output frame_line_n, output host_do, output host_oe, input nibble_bus);
  modport target (input frame_line_n, output tgt_do, output tgt_oe, input nibble_bus);
endinterface
`default_nettype wire

//--- core/nbt_host.sv
// Host end of the nibble bus: issues single-byte reads, writes and aborts.
// Assumes target answers with the two-flop input latency of its own design.
`timescale 1ns/10ps
`default_nettype none
module nbt_host #(
  parameter int SYNC_WAIT = 16
) (
  input wire logic clk,
  input wire logic rstn,
  nbt_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_abort,
  input wire logic [3:0] chip_select_nibble,
  input wire logic [27:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy_q,
  output logic done_q,
  output logic [7:0] rdata_q
);
  import nbt_pkg::*;
  // ==========================================================
  // Nibble script: 0 start, 1 select, 2-8 address, 9 size, then data/turnaround
  logic [4:0] slot_q;
  logic wr_q;
  logic [27:0] a_q;
  logic [7:0] w_q;
  logic [3:0] sel_q;
  logic frame_q, oe_q, wait_q;
  logic [3:0] do_q;
  logic [4:0] tmo_q;
  logic [1:0] rx_q;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      slot_q <= 5'h00;
      wr_q <= 1'b0;
      a_q <= 28'h000_0000;
      w_q <= 8'h00;
      sel_q <= 4'h0;
      frame_q <= 1'b1;
      oe_q <= 1'b1;
      do_q <= NIB_ONES;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      wait_q <= 1'b0;
      tmo_q <= 5'h00;
      rx_q <= 2'h0;
      rdata_q <= 8'h00;
    end
    else
    begin
      done_q <= 1'b0;
      // R18 no abort mid-write or while target may drive
      if (req_abort && !(busy_q && (wr_q || wait_q)))
      begin
        // R17 abort: frame pulse with 1111
        busy_q <= 1'b0;
        wait_q <= 1'b0;
        frame_q <= 1'b0;
        do_q <= ABORT_CODE;
        oe_q <= 1'b1;
      end
      else if (!busy_q && req)
      begin
        // R02 R15 start with frame low
        busy_q <= 1'b1;
        wr_q <= req_write;
        a_q <= req_addr;
        w_q <= req_wdata;
        sel_q <= chip_select_nibble;
        frame_q <= 1'b0;
        oe_q <= 1'b1;
        do_q <= req_write ? START_WRITE : START_READ;
        slot_q <= 5'h01;
      end
      else if (busy_q && !wait_q)
      begin
        frame_q <= 1'b1;
        slot_q <= slot_q + 5'h01;
        if (slot_q == 5'h01)
          do_q <= sel_q;
        // R05 address msn first
        else if (slot_q <= 5'h08)
        begin
          do_q <= a_q[27:24];
          a_q <= {a_q[23:0], 4'h0};
        end
        // R06 size one byte
        else if (slot_q == 5'h09)
          do_q <= SIZE_ONE_BYTE;
        // R11 write data low then high
        else if (wr_q && slot_q == 5'h0A)
          do_q <= w_q[3:0];
        else if (wr_q && slot_q == 5'h0B)
          do_q <= w_q[7:4];
        // R07 R12 turnaround ones then float
        else if (slot_q == (wr_q ? 5'h0C : 5'h0A))
          do_q <= NIB_ONES;
        else
        begin
          oe_q <= 1'b0;
          wait_q <= 1'b1;
          tmo_q <= 5'h00;
          rx_q <= 2'h0;
        end
      end
      else if (busy_q)
      begin
        // Collect sync and data; a timeout keeps a silent target from hanging us
        tmo_q <= tmo_q + 5'h01;
        if (rx_q == 2'h0 && bus.nibble_bus == SYNC_READY)
          rx_q <= wr_q ? 2'h3 : 2'h1;
        else if (rx_q == 2'h1)
        begin
          rdata_q[3:0] <= bus.nibble_bus;
          rx_q <= 2'h2;
        end
        else if (rx_q == 2'h2)
        begin
          rdata_q[7:4] <= bus.nibble_bus;
          rx_q <= 2'h3;
        end
        // R10 R14 host resumes after target turnaround
        if (rx_q == 2'h3 || tmo_q == 5'(SYNC_WAIT))
        begin
          busy_q <= 1'b0;
          wait_q <= 1'b0;
          done_q <= (rx_q == 2'h3);
          oe_q <= 1'b1;
          do_q <= NIB_ONES;
        end
      end
      else
      begin
        frame_q <= 1'b1;
        oe_q <= 1'b1;
        do_q <= NIB_ONES;
      end
    end
  assign bus.frame_line_n = frame_q;
  assign bus.host_do = do_q;
  assign bus.host_oe = oe_q;
endmodule
`default_nettype wire

//--- testbench/nbt_chk.sv
// Checker of the nibble bus wire between the host and target ends.
// Assumes the bench places it beside the interface; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module nbt_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic frame_line_n,
  input wire logic [3:0] host_do,
  input wire logic host_oe,
  input wire logic [3:0] tgt_do,
  input wire logic tgt_oe,
  input wire logic [3:0] nibble_bus
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ==========
  // Ownership
  property p_one_driver;
    !(host_oe && tgt_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive");
  property p_tgt_framed;
    tgt_oe |-> frame_line_n;
  endproperty
  a_tgt_framed: assert property (p_tgt_framed) else $error("target drives in frame");
  property p_tgt_short;
    $rose(tgt_oe) |-> ##[1:5] !tgt_oe;
  endproperty
  a_tgt_short: assert property (p_tgt_short) else $error("target holds bus");
  // Sync must appear in the first or second slot the target drives
  property p_tgt_sync;
    $rose(tgt_oe) |-> ##[0:1] (tgt_oe && tgt_do == 4'h0);
  endproperty
  a_tgt_sync: assert property (p_tgt_sync) else $error("no sync nibble");
  // ==========
  // Turnarounds
  property p_tgt_ones;
    $fell(tgt_oe) |-> $past(tgt_do) == 4'hF;
  endproperty
  a_tgt_ones: assert property (p_tgt_ones) else $error("target left without ones");
  property p_host_ones;
    $fell(host_oe) |-> $past(host_do) == 4'hF;
  endproperty
  a_host_ones: assert property (p_host_ones) else $error("host left without ones");
  property p_host_back;
    $fell(tgt_oe) |-> ##[0:4] host_oe;
  endproperty
  a_host_back: assert property (p_host_back) else $error("host not back");
  // ==========
  // Framing; codes written out, not taken from the package
  property p_start_code;
    !frame_line_n |-> host_oe && (nibble_bus inside {4'hD, 4'hE, 4'hF});
  endproperty
  a_start_code: assert property (p_start_code) else $error("bad start nibble");
  property p_frame_pulse;
    $fell(frame_line_n) |=> frame_line_n;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame too long");
  c_read: cover property (!frame_line_n && nibble_bus == 4'hD);
  c_write: cover property (!frame_line_n && nibble_bus == 4'hE);
  c_abort: cover property (!frame_line_n && nibble_bus == 4'hF);
endmodule
`default_nettype wire

//--- testbench/test_nibble_bus_cycle_target.sv
// Bench joining host and target ends through the nibble bus interface.
// Assumes the host parameter default and straps driven from here.
`timescale 1ns/10ps
`default_nettype none
module test_nibble_bus_cycle_target;
  import nbt_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic req_abort = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [27:0] req_addr = 28'h000_0000;
  logic [7:0] req_wdata = 8'h00;
  logic [3:0] strap = 4'hA;
  logic [7:0] rd_byte = 8'h3C;
  logic busy, done, standby, wr_stb, rd_stb, oe_prev;
  logic [7:0] rdata, wr_byte;
  logic [27:0] addr;
  int num_errors = 0;
  int check_count = 0;
  int wr_n = 0;
  int rd_n = 0;
  int oe_n = 0;
  int done_n = 0;
  nbt_if bus ();
  nbt_host i_nbt_host (.clk(clk), .rstn(rstn), .bus(bus), .req(req),
    .req_write(req_write), .req_abort(req_abort), .chip_select_nibble(sel),
    .req_addr(req_addr), .req_wdata(req_wdata), .busy_q(busy), .done_q(done),
    .rdata_q(rdata));
  nbt_target i_nbt_target (.clk(clk), .rstn(rstn), .bus(bus),
    .strapped_identity(strap), .rd_byte(rd_byte), .addr_q(addr),
    .wr_byte_q(wr_byte), .wr_stb_q(wr_stb), .rd_stb_q(rd_stb), .standby_q(standby));
  nbt_chk i_nbt_chk (.clk(clk), .rstn(rstn), .frame_line_n(bus.frame_line_n),
    .host_do(bus.host_do), .host_oe(bus.host_oe), .tgt_do(bus.tgt_do),
    .tgt_oe(bus.tgt_oe), .nibble_bus(bus.nibble_bus));
  always #4 clk = ~clk;
  // Count strobes and target bus grabs; pulses last one clock
  always @(posedge clk)
  begin
    if (wr_stb === 1'b1) wr_n++;
    if (rd_stb === 1'b1) rd_n++;
    if (done === 1'b1) done_n++;
    if (bus.tgt_oe === 1'b1 && oe_prev !== 1'b1) oe_n++;
    oe_prev = bus.tgt_oe;
  end
  // ==========
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Host is idle, so req is taken at the next edge; busy is read at falling edges
  task automatic cyc(input logic wr, input logic [3:0] cs, input logic [27:0] a,
    input logic [7:0] d);
    req <= 1'b1;
    req_write <= wr;
    sel <= cs;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    repeat (60) if (busy === 1'b1) @(negedge clk);
    check(busy, 1'b0);
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Tests
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Write then read back to back
    cyc(1'b1, 4'hA, 28'h123_4567, 8'hA5);
    check(addr, 28'h123_4567);
    check(wr_byte, 8'hA5);
    check(wr_n, 1);
    check(done_n, 1);
    cyc(1'b0, 4'hA, 28'hFED_CBA9, 8'h00);
    check(addr, 28'hFED_CBA9);
    check(rdata, 8'h3C);
    check(rd_n, 1);
    check(done_n, 2);
    // Wrong select: no strobe, no drive, back in standby
    cyc(1'b1, 4'h5, 28'h000_0001, 8'h11);
    check(wr_n, 1);
    check(done_n, 2);
    check(oe_n, 2);
    check(standby, 1'b1);
    // Abort while idle, then a read on a new strap still works
    req_abort <= 1'b1;
    @(posedge clk);
    req_abort <= 1'b0;
    strap <= 4'h0;
    rd_byte <= 8'hC3;
    repeat (4) @(posedge clk);
    // abort a selected read in its address phase, never a write
    req <= 1'b1;
    req_write <= 1'b0;
    sel <= 4'h0;
    req_addr <= 28'h555_5555;
    @(posedge clk);
    req <= 1'b0;
    repeat (4) @(posedge clk);
    req_abort <= 1'b1;
    @(posedge clk);
    req_abort <= 1'b0;
    repeat (6) @(posedge clk);
    check(rd_n, 1);
    check(done_n, 2);
    check(oe_n, 2);
    check(standby, 1'b1);
    cyc(1'b0, 4'h0, 28'h0AB_CDEF, 8'h00);
    check(rdata, 8'hC3);
    check(rd_n, 2);
    check(done_n, 3);
    close_out;
  end
  // Watchdog well beyond the five cycles above
  initial
  begin
    #(8 * 3000);
    num_errors++;
    close_out;
  end
endmodule
`default_nettype wire
